// ===== common/trel_pkg.sv
/*
 * constants and carrier types of the temperature readout and event logic.
 * assumes a single clock domain and a host-side bus engine that owns the wire protocol.
 */
package trel_pkg;

  // ****************************************************************
  // register select codes
  // ****************************************************************
  localparam logic [2:0] ADDR_CAP  = 3'h0;
  localparam logic [2:0] ADDR_CFG  = 3'h1;
  localparam logic [2:0] ADDR_HIGH = 3'h2;
  localparam logic [2:0] ADDR_LOW  = 3'h3;
  localparam logic [2:0] ADDR_CRIT = 3'h4;
  localparam logic [2:0] ADDR_TEMP = 3'h5;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CFG_MODE      = 0;
  localparam int unsigned CFG_POL       = 1;
  localparam int unsigned CFG_CRIT_ONLY = 2;
  localparam int unsigned CFG_CTRL      = 3;
  localparam int unsigned CFG_STS       = 4;
  localparam int unsigned CFG_CLEAR     = 5;
  localparam int unsigned CFG_SENSOR_POWER_DOWN      = 8;
  localparam int unsigned CFG_TRIP_MARGIN_SELECT      = 9;
  localparam int unsigned CAP_RES       = 3;
  localparam int unsigned TEMP_CRIT     = 15;
  localparam int unsigned TEMP_HIGH     = 14;
  localparam int unsigned TEMP_LOW      = 13;
  localparam int unsigned TEMP_SIGN     = 12;

  // ****************************************************************
  // masks, hysteresis steps (1/16 degree units) and reset values
  // ****************************************************************
  localparam logic [12:0] LIMIT_MASK  = 13'h1FFC;
  localparam logic [12:0] RES_MASK_9  = 13'h1FF8;
  localparam logic [12:0] RES_MASK_10 = 13'h1FFC;
  localparam logic [12:0] RES_MASK_11 = 13'h1FFE;
  localparam logic [12:0] RES_MASK_12 = 13'h1FFF;
  localparam logic [13:0] TRIP_MARGIN_SELECT_NONE   = 14'h0000;
  localparam logic [13:0] TRIP_MARGIN_SELECT_1P5    = 14'h0018;
  localparam logic [13:0] TRIP_MARGIN_SELECT_3      = 14'h0030;
  localparam logic [13:0] TRIP_MARGIN_SELECT_6      = 14'h0060;
  localparam logic [12:0] TEMP_RST    = 13'h0000;
  localparam logic [12:0] LIMIT_RST   = 13'h0000;

  typedef struct packed {
    logic [1:0] trip_margin_select;
    logic       sensor_power_down;
    logic       crit_only;
    logic       ev_ctrl;
    logic       pol;
    logic       mode;
  } trel_cfg_s;

  localparam trel_cfg_s CFG_RST = '{trip_margin_select: 2'h0, sensor_power_down: 1'b0, crit_only: 1'b0,
                                    ev_ctrl: 1'b0, pol: 1'b0, mode: 1'b0};

  typedef struct packed {
    logic crit;
    logic high;
    logic low;
  } trel_flags_s;

endpackage

// ===== hw/trel_top.sv
/*
 * temperature result formatting, limit comparison with hysteresis and event pin control.
 * assumes the bus engine and the converter run on CLK_I; the resolution strap is asynchronous.
 */
// How it works
// - crit flag set at or above critical
// - high flag set strictly above high
// - low flag set strictly below low
// - bit twelve is the sign
// - unsupported fraction bits read zero
// - temperature is 13-bit two's complement sixteenths
// - limits quarter-degree, low two bits zero
// - interrupt mode latches every window crossing outside shutdown
// - above critical, event stays despite clears
// - clear above critical deferred until drop
// - comparator mode follows window outside
// - critical-only asserts solely above critical
// - clears ignored in comparator, critical-only
// - thresholds from limits plus hysteresis
// - shutdown freezes recorded temperature
// - shutdown holds event state; enable, polarity writes still apply
// - limit writes re-evaluate event immediately
// - temperature updates only on samples
// - config bit zero selects event mode
// - hysteresis codes none, 1.5, 3, 6
// - enable bit and polarity bit
// - clear bit always reads zero
`timescale 1ns/1ps

module trel_top (
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [2:0]  REG_SEL_I,
  input  wire logic        REG_WR_I,
  input  wire logic [15:0] REG_WDATA_I,
  output logic      [15:0] REG_RDATA_O,
  input  wire logic        SAMPLE_VALID_I,
  input  wire logic [12:0] SAMPLE_TEMP_I,
  input  wire logic [1:0]  RES_CAP_I,
  output logic             EVENT_O,
  output logic             EVENT_OE_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  trel_pkg::trel_cfg_s   cfg_reg;
  trel_pkg::trel_flags_s flags_reg;
  trel_pkg::trel_flags_s flags_next;
  logic [12:0]           temp_reg;
  logic [12:0]           high_reg;
  logic [12:0]           low_reg;
  logic [12:0]           crit_reg;
  logic [1:0]            res_meta_reg;
  logic [1:0]            res_sync_reg;
  logic                  latch_reg;
  logic                  pend_clr_reg;
  logic                  assert_reg;
  logic                  assert_next;
  logic                  oe_reg;
  logic [15:0]           rdata_reg;
  logic [12:0]           res_mask;
  logic [13:0]           trip_margin_select;
  logic signed [13:0]    t_s;
  logic signed [13:0]    hi_s;
  logic signed [13:0]    lo_s;
  logic signed [13:0]    cr_s;
  logic                  wr_cfg;
  logic                  clr_pulse;
  logic                  crossing;

  assign wr_cfg    = REG_WR_I && (REG_SEL_I == trel_pkg::ADDR_CFG);
  assign clr_pulse = wr_cfg && REG_WDATA_I[trel_pkg::CFG_CLEAR];

  // ****************************************************************
  // strap synchroniser
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      res_meta_reg <= 2'h0;
      res_sync_reg <= 2'h0;
    end else begin
      res_meta_reg <= RES_CAP_I;
      res_sync_reg <= res_meta_reg;
    end
  end

  always_comb begin
    unique case (res_sync_reg)
      2'h0: res_mask = trel_pkg::RES_MASK_9;
      2'h1: res_mask = trel_pkg::RES_MASK_10;
      2'h2: res_mask = trel_pkg::RES_MASK_11;
      2'h3: res_mask = trel_pkg::RES_MASK_12;
    endcase
  end

  // ****************************************************************
  // configuration and limit registers
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg_reg <= trel_pkg::CFG_RST;
    end else if (wr_cfg) begin
      cfg_reg.mode      <= REG_WDATA_I[trel_pkg::CFG_MODE];
      cfg_reg.pol       <= REG_WDATA_I[trel_pkg::CFG_POL];
      cfg_reg.crit_only <= REG_WDATA_I[trel_pkg::CFG_CRIT_ONLY];
      cfg_reg.ev_ctrl   <= REG_WDATA_I[trel_pkg::CFG_CTRL];
      cfg_reg.sensor_power_down      <= REG_WDATA_I[trel_pkg::CFG_SENSOR_POWER_DOWN];
      cfg_reg.trip_margin_select      <= REG_WDATA_I[trel_pkg::CFG_TRIP_MARGIN_SELECT +: 2];
    end
  end

  // limits keep only quarter-degree bits; writes land at any time
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      high_reg <= trel_pkg::LIMIT_RST;
      low_reg  <= trel_pkg::LIMIT_RST;
      crit_reg <= trel_pkg::LIMIT_RST;
    end else if (REG_WR_I) begin
      if (REG_SEL_I == trel_pkg::ADDR_HIGH) begin
        high_reg <= REG_WDATA_I[12:0] & trel_pkg::LIMIT_MASK;
      end
      if (REG_SEL_I == trel_pkg::ADDR_LOW) begin
        low_reg <= REG_WDATA_I[12:0] & trel_pkg::LIMIT_MASK;
      end
      if (REG_SEL_I == trel_pkg::ADDR_CRIT) begin
        crit_reg <= REG_WDATA_I[12:0] & trel_pkg::LIMIT_MASK;
      end
    end
  end

  // ****************************************************************
  // recorded temperature
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      temp_reg <= trel_pkg::TEMP_RST;
    end else if (SAMPLE_VALID_I && !cfg_reg.sensor_power_down) begin
      temp_reg <= SAMPLE_TEMP_I & res_mask;
    end
  end

  // ****************************************************************
  // comparison with hysteresis
  // ****************************************************************
  always_comb begin
    unique case (cfg_reg.trip_margin_select)
      2'h0: trip_margin_select = trel_pkg::TRIP_MARGIN_SELECT_NONE;
      2'h1: trip_margin_select = trel_pkg::TRIP_MARGIN_SELECT_1P5;
      2'h2: trip_margin_select = trel_pkg::TRIP_MARGIN_SELECT_3;
      2'h3: trip_margin_select = trel_pkg::TRIP_MARGIN_SELECT_6;
    endcase
  end

  // one extra bit so a limit minus hysteresis cannot wrap around
  assign t_s  = {temp_reg[trel_pkg::TEMP_SIGN], temp_reg};
  assign hi_s = {high_reg[trel_pkg::TEMP_SIGN], high_reg};
  assign lo_s = {low_reg[trel_pkg::TEMP_SIGN], low_reg};
  assign cr_s = {crit_reg[trel_pkg::TEMP_SIGN], crit_reg};

  // raised flags hold until the temperature backs off by the margin
  always_comb begin
    flags_next.crit = flags_reg.crit ? (t_s >= cr_s - $signed(trip_margin_select))
                                     : (t_s >= cr_s);
    flags_next.high = flags_reg.high ? (t_s > hi_s - $signed(trip_margin_select))
                                     : (t_s > hi_s);
    flags_next.low  = flags_reg.low  ? (t_s < lo_s + $signed(trip_margin_select))
                                     : (t_s < lo_s);
  end

  // evaluated every cycle, so a limit write acts at once
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ****************************************************************
  // interrupt latch and deferred clear
  // ****************************************************************
  assign crossing = (flags_next.high != flags_reg.high) || (flags_next.low != flags_reg.low);

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      latch_reg    <= 1'b0;
      pend_clr_reg <= 1'b0;
    end else if (!cfg_reg.mode || cfg_reg.crit_only) begin
      latch_reg    <= 1'b0;
      pend_clr_reg <= 1'b0;
    end else if (crossing && !cfg_reg.sensor_power_down) begin
      latch_reg    <= 1'b1;  // crossing wins over a clear
      pend_clr_reg <= 1'b0;
    end else if (clr_pulse && flags_reg.crit) begin
      pend_clr_reg <= 1'b1;
    end else if (clr_pulse || (pend_clr_reg && !flags_reg.crit)) begin
      latch_reg    <= 1'b0;
      pend_clr_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // event decision
  // ****************************************************************
  always_comb begin
    if (cfg_reg.crit_only) begin
      assert_next = flags_reg.crit;
    end else if (cfg_reg.mode) begin
      assert_next = latch_reg || flags_reg.crit;
    end else begin
      assert_next = flags_reg.high || flags_reg.low || flags_reg.crit;
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      assert_reg <= 1'b0;
    end else if (!cfg_reg.sensor_power_down) begin
      assert_reg <= assert_next;
    end
  end

  // open drain: disabled pin follows polarity, grounded when active high
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= cfg_reg.ev_ctrl ? (assert_reg ^ cfg_reg.pol) : cfg_reg.pol;
    end
  end

  assign EVENT_OE_O = oe_reg;
  assign EVENT_O    = 1'b0;

  // ****************************************************************
  // read path
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= 16'h0000;  // clear bit and unmapped selects read zero
      unique case (REG_SEL_I)
        trel_pkg::ADDR_CAP: begin
          rdata_reg[trel_pkg::CAP_RES +: 2] <= res_sync_reg;
        end
        trel_pkg::ADDR_CFG: begin
          rdata_reg[trel_pkg::CFG_MODE]      <= cfg_reg.mode;
          rdata_reg[trel_pkg::CFG_POL]       <= cfg_reg.pol;
          rdata_reg[trel_pkg::CFG_CRIT_ONLY] <= cfg_reg.crit_only;
          rdata_reg[trel_pkg::CFG_CTRL]      <= cfg_reg.ev_ctrl;
          rdata_reg[trel_pkg::CFG_STS]       <= assert_reg && cfg_reg.ev_ctrl;
          rdata_reg[trel_pkg::CFG_SENSOR_POWER_DOWN]      <= cfg_reg.sensor_power_down;
          rdata_reg[trel_pkg::CFG_TRIP_MARGIN_SELECT +: 2] <= cfg_reg.trip_margin_select;
        end
        trel_pkg::ADDR_HIGH: begin
          rdata_reg[12:0] <= high_reg;
        end
        trel_pkg::ADDR_LOW: begin
          rdata_reg[12:0] <= low_reg;
        end
        trel_pkg::ADDR_CRIT: begin
          rdata_reg[12:0] <= crit_reg;
        end
        trel_pkg::ADDR_TEMP: begin
          rdata_reg <= {flags_reg.crit, flags_reg.high, flags_reg.low, temp_reg};
        end
        default: begin
          rdata_reg <= 16'h0000;
        end
      endcase
    end
  end

  assign REG_RDATA_O = rdata_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_limit_low_bits: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (high_reg[1:0] == 2'h0) && (low_reg[1:0] == 2'h0) && (crit_reg[1:0] == 2'h0))
    else $error("limit low bits not zero");

  chk_crit_flag_set: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (t_s >= cr_s) |=> flags_reg.crit)
    else $error("critical flag missed");

  chk_high_flag_set: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (!flags_reg.high && (t_s <= hi_s)) |=> !flags_reg.high)
    else $error("high flag raised at or below limit");

  chk_low_flag_set: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (t_s < lo_s) |=> flags_reg.low)
    else $error("low flag missed");

  chk_res_mask_zero: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    SAMPLE_VALID_I && !cfg_reg.sensor_power_down |=> (temp_reg & ~$past(res_mask)) == 13'h0000)
    else $error("unsupported fraction bits set");

  chk_comp_follow: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (!cfg_reg.mode && !cfg_reg.crit_only && !cfg_reg.sensor_power_down)
    |=> assert_reg == $past(flags_reg.high || flags_reg.low || flags_reg.crit))
    else $error("comparator event wrong");

  chk_crit_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (cfg_reg.mode && flags_reg.crit && !cfg_reg.sensor_power_down) |=> assert_reg)
    else $error("event dropped above critical");

  chk_sensor_power_down_freeze: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    cfg_reg.sensor_power_down ##1 cfg_reg.sensor_power_down |-> $stable(temp_reg) && $stable(assert_reg))
    else $error("state changed during shutdown");

  // only a config read carries the clear bit; limit reads use that bit as a weight
  chk_clear_reads_zero: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ($past(REG_SEL_I) == trel_pkg::ADDR_CFG) |-> !rdata_reg[trel_pkg::CFG_CLEAR])
    else $error("clear bit read as one");

  chk_pin_drive: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    1'b1 |=> EVENT_OE_O == $past(cfg_reg.ev_ctrl ? (assert_reg ^ cfg_reg.pol) : cfg_reg.pol))
    else $error("event pin drive wrong");

  chk_crit_only_event: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (cfg_reg.crit_only && !cfg_reg.sensor_power_down) |=> assert_reg == $past(flags_reg.crit))
    else $error("critical-only event wrong");

  chk_clear_ignored: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (!cfg_reg.mode || cfg_reg.crit_only) |=> !latch_reg)
    else $error("latch held outside interrupt mode");

  chk_latch_on_cross: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (cfg_reg.mode && !cfg_reg.crit_only && crossing && !cfg_reg.sensor_power_down) |=> latch_reg)
    else $error("window crossing not latched");

  chk_deferred_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (cfg_reg.mode && !cfg_reg.crit_only && !crossing && clr_pulse && flags_reg.crit)
    |=> pend_clr_reg)
    else $error("clear above critical not deferred");

  chk_temp_on_sample: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (!SAMPLE_VALID_I || cfg_reg.sensor_power_down) |=> $stable(temp_reg))
    else $error("temperature moved without a sample");

  chk_status_copy: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ($past(REG_SEL_I) == trel_pkg::ADDR_CFG)
    |-> rdata_reg[trel_pkg::CFG_STS] == $past(assert_reg && cfg_reg.ev_ctrl))
    else $error("status bit wrong");

endmodule

// ===== testbench/trel_host_model.sv
/*
 * host side partner: register select, write strobe and data, converter samples,
 * and the pull-up on the open-drain event pin.
 * assumes every request is launched just after a rising edge of clk_i.
 */
`timescale 1ns/1ps

module trel_host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        ev_i,
  input  wire logic        ev_oe_i,
  output logic      [2:0]  sel_o,
  output logic             wr_o,
  output logic      [15:0] wdata_o,
  output logic             svalid_o,
  output logic      [12:0] stemp_o,
  output logic             pin_o
);
  // ****************************************************************
  // pin level and idle values
  // ****************************************************************
  // pulled up, so a released pin reads high
  assign pin_o = ev_oe_i ? ev_i : 1'b1;

  // called once at time zero so the bench thread is the only driver
  task automatic idle();
    sel_o    <= 3'h7;
    wr_o     <= 1'b0;
    wdata_o  <= 16'h0000;
    svalid_o <= 1'b0;
    stemp_o  <= 13'h0000;
  endtask

  // ****************************************************************
  // transfers
  // ****************************************************************
  task automatic wr(input logic [2:0] s, input logic [15:0] v);
    @(posedge clk_i);
    sel_o   <= s;
    wr_o    <= 1'b1;
    wdata_o <= v;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // stale data must not pass for a new write
    wdata_o <= ~v;
  endtask

  task automatic rd(input logic [2:0] s, output logic [15:0] v);
    @(posedge clk_i);
    sel_o <= s;
    @(posedge clk_i);
    #1;
    v = rdata_i;
  endtask

  task automatic sample(input logic [12:0] t);
    @(posedge clk_i);
    svalid_o <= 1'b1;
    stemp_o  <= t;
    @(posedge clk_i);
    svalid_o <= 1'b0;
    stemp_o  <= ~t;
  endtask
endmodule

// ===== testbench/tb.sv
/*
 * self-checking bench of the temperature readout and event logic: reset, resolution and limit cases,
 * then a table of samples, then limit-write, hysteresis, polarity, interrupt, shutdown and reset cases.
 * assumes trel_host_model drives the register and sample ports.
 */
`timescale 1ns/1ps

module tb;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  typedef struct packed {
    logic [12:0] t;
    logic [15:0] rd;
    logic        pin;
  } trel_row_s;

  localparam trel_row_s ROWS [7] = '{
    '{13'h0320, 16'h0320, 1'b1}, '{13'h0321, 16'h4321, 1'b0}, '{13'h0190, 16'h0190, 1'b1},
    '{13'h018F, 16'h218F, 1'b0}, '{13'h0640, 16'hC640, 1'b0}, '{13'h1E70, 16'h3E70, 1'b0},
    '{13'h0200, 16'h0200, 1'b1}};

  logic        clk = 1'b0;
  logic        rst;
  logic [1:0]  res_cap;
  logic [2:0]  sel;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        sval;
  logic [12:0] stemp;
  logic        ev;
  logic        ev_oe;
  logic        pin;
  logic [15:0] d;
  int          errors = 0;
  int          check_count = 0;

  always #2 clk = ~clk;

  trel_top uut (.CLK_I(clk), .SYS_RST_I(rst), .REG_SEL_I(sel), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SAMPLE_VALID_I(sval),
    .SAMPLE_TEMP_I(stemp), .RES_CAP_I(res_cap), .EVENT_O(ev), .EVENT_OE_O(ev_oe));

  trel_host_model host (.clk_i(clk), .rdata_i(rdata), .ev_i(ev), .ev_oe_i(ev_oe),
    .sel_o(sel), .wr_o(wr), .wdata_o(wdata), .svalid_o(sval), .stemp_o(stemp),
    .pin_o(pin));

  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  // event pin moves at most five edges after its cause (deferred clear); six leaves margin
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  task automatic rdchk(input logic [2:0] s, input logic [15:0] exp);
    host.rd(s, d);
    chk($sformatf("reg%0d", s), exp, d);
  endtask

  task automatic pinchk(input logic exp);
    settle();
    chk("pin", {15'h0, exp}, {15'h0, pin});
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    logic [12:0] m;
    logic [12:0] t;
    logic [15:0] c;
    rst     <= 1'b1;
    res_cap <= 2'h3;
    host.idle();
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdchk(trel_pkg::ADDR_CFG, 16'h0000);
    host.wr(trel_pkg::ADDR_TEMP, 16'h1234);
    rdchk(trel_pkg::ADDR_TEMP, 16'h8000);
    rdchk(3'h6, 16'h0000);
    chk("oe", 16'h0000, {15'h0, ev_oe});
    for (int c2 = 0; c2 < 4; c2++) begin
      res_cap <= 2'(c2);
      m = 13'h1FFF << (3 - c2);
      settle();
      host.sample(13'h0327);
      rdchk(trel_pkg::ADDR_TEMP, {3'b110, 13'h0327 & m});
      host.rd(trel_pkg::ADDR_CAP, d);
      chk("cap", 16'(c2) << 3, d & 16'h0018);
    end
    host.wr(trel_pkg::ADDR_HIGH, 16'hFFFF);
    rdchk(trel_pkg::ADDR_HIGH, 16'h1FFC);
    host.wr(trel_pkg::ADDR_HIGH, 16'h0323);
    rdchk(trel_pkg::ADDR_HIGH, 16'h0320);
    host.wr(trel_pkg::ADDR_LOW, 16'h0190);
    host.wr(trel_pkg::ADDR_CRIT, 16'h0640);
    host.wr(trel_pkg::ADDR_CFG, 16'h0008);
    foreach (ROWS[i]) begin
      host.sample(ROWS[i].t);
      pinchk(ROWS[i].pin);
      rdchk(trel_pkg::ADDR_TEMP, ROWS[i].rd);
    end
    host.wr(trel_pkg::ADDR_HIGH, 16'h01FC);
    pinchk(1'b0);
    host.wr(trel_pkg::ADDR_HIGH, 16'h0320);
    pinchk(1'b1);
    for (int h = 0; h < 4; h++) begin
      host.wr(trel_pkg::ADDR_CFG, 16'h0008 | (16'(h) << 9));
      t = (h == 0) ? 13'h0000 : 13'h0018 << (h - 1);
      host.sample(13'h0321);
      host.sample(13'h0321 - t);
      settle();
      rdchk(trel_pkg::ADDR_TEMP, {3'b010, 13'h0321 - t});
      host.sample(13'h0320 - t);
      settle();
      rdchk(trel_pkg::ADDR_TEMP, {3'b000, 13'h0320 - t});
    end
    for (int j = 0; j < 2; j++) begin
      host.sample(j == 1 ? 13'h0321 : 13'h0200);
      for (int i = 0; i < 4; i++) begin
        c = {12'h000, i[1], 1'b0, i[0], 1'b0};
        host.wr(trel_pkg::ADDR_CFG, c);
        settle();
        chk("oe", {15'h0, i[1] ? (j[0] ^ i[0]) : i[0]}, {15'h0, ev_oe});
        rdchk(trel_pkg::ADDR_CFG, c | {11'h000, j[0] & i[1], 4'h0});
      end
    end
    host.sample(13'h0200);
    host.wr(trel_pkg::ADDR_CFG, 16'h0009);
    pinchk(1'b1);
    host.sample(13'h0321);
    host.sample(13'h0200);
    pinchk(1'b0);
    host.wr(trel_pkg::ADDR_CFG, 16'h0029);
    pinchk(1'b1);
    rdchk(trel_pkg::ADDR_CFG, 16'h0009);
    host.sample(13'h0700);
    settle();
    host.wr(trel_pkg::ADDR_CFG, 16'h0029);
    pinchk(1'b0);
    host.sample(13'h0500);
    pinchk(1'b1);
    host.wr(trel_pkg::ADDR_CFG, 16'h0008);
    host.wr(trel_pkg::ADDR_CFG, 16'h0028);
    pinchk(1'b0);
    host.wr(trel_pkg::ADDR_CFG, 16'h000C);
    pinchk(1'b1);
    host.sample(13'h0700);
    host.wr(trel_pkg::ADDR_CFG, 16'h002C);
    pinchk(1'b0);
    host.wr(trel_pkg::ADDR_CFG, 16'h010C);
    host.sample(13'h0200);
    pinchk(1'b0);
    rdchk(trel_pkg::ADDR_TEMP, 16'hC700);
    // clearing event control releases the shared line while the sensor sleeps
    host.wr(trel_pkg::ADDR_CFG, 16'h0104);
    pinchk(1'b1);
    host.wr(trel_pkg::ADDR_CFG, 16'h000C);
    host.sample(13'h0200);
    pinchk(1'b1);
    rdchk(trel_pkg::ADDR_TEMP, 16'h0200);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(trel_pkg::ADDR_CFG, 16'h0000);
    rdchk(trel_pkg::ADDR_TEMP, 16'h8000);
    chk("oe", 16'h0000, {15'h0, ev_oe});
    stop_test();
  end
endmodule
